// File: shared/cfc_pkg.sv
// Purpose: constants for the CAN fault confinement block
// Assumes: one protocol clock, bit period marked by a sample pulse
// Notes: counts are in bit periods unless named otherwise
package cfc_pkg;
  // ==========================================
  // error kinds reported by the detector
  localparam logic [2:0] KIND_BIT = 3'h0;
  localparam logic [2:0] KIND_STUFF = 3'h1;
  localparam logic [2:0] KIND_FORM = 3'h2;
  localparam logic [2:0] KIND_ACK = 3'h3;
  localparam logic [2:0] KIND_CRC = 3'h4;
  // ==========================================
  // thresholds and state codes
  localparam logic [7:0] WARN_LEVEL = 8'h60;
  localparam logic [7:0] PASSIVE_LEVEL = 8'h80;
  localparam logic [7:0] TEC_OFF_LEVEL = 8'hF8;
  localparam logic [7:0] TEC_STEP = 8'h08;
  localparam logic [7:0] REC_STEP = 8'h08;
  localparam logic [7:0] REC_RELOAD = 8'h7F;
  localparam logic [1:0] CODE_ACTIVE = 2'h0;
  localparam logic [1:0] CODE_WARN = 2'h1;
  localparam logic [1:0] CODE_PASSIVE = 2'h3;
  // ==========================================
  // bit counts and the count of idle runs
  localparam logic [3:0] FLAG_BITS = 4'h6;
  localparam logic [3:0] DELIM_BITS = 4'h8;
  localparam logic [3:0] SUSPEND_BITS = 4'h8;
  localparam logic [3:0] IDLE_RUN_BITS = 4'hB;
  localparam logic [7:0] IDLE_RUNS = 8'h80;
  // ==========================================
  // reset values
  localparam logic [7:0] TEC_RESET = 8'h00;
  localparam logic [7:0] REC_RESET = 8'h00;
  typedef enum logic [2:0] {
    EF_IDLE = 3'b000,
    EF_WAIT_CRC = 3'b001,
    EF_ARMED = 3'b010,
    EF_FLAG = 3'b011,
    EF_DELIM_WAIT = 3'b100,
    EF_DELIM = 3'b101
  } cfc_ef_state_t;
endpackage : cfc_pkg

// File: design/cfc_fault_confine.sv
// Purpose: error frame timing, retransmission, error states, bus-off recovery
// Assumes: BIT_TICK pulses once at the start of every bit period
// Notes: event inputs come from logic on REF_CLK; RX_PIN is synchronised
//
// Notes on behaviour
// - bit, stuff, form or ack error: error flag starts the next bit period
// - crc error: error flag starts the bit after the ack delimiter
// - transmitter resends the interrupted frame after the error frame
// - one-attempt mode: no resend after an aborted frame
// - counter at 96 or more sets its warning bit
// - counter at 128 or more means error passive, upper status bit set
// - state codes: 00 below 96, 01 for 96 to 127, 11 when passive
// - passive lone transmitter: unacknowledged retries do not raise the count
// - active node sends six dominant bits as error flag
// - passive node sends six recessive bits as error flag
// - passive transmitter waits eight recessive bits after intermission
// - bus-off: no storing, but timestamp toggles, receive count and valid update
// - after init then operating mode, 128 runs of 11 recessive bits recover
// - plus eight from 248 to 255 leaves count unchanged and goes bus-off
// - transmit count is eight bits, receive count seven bits
// - counter increments land on the first error delimiter bit
// - bus-off holds the transmit pin recessive
// - flag type uses counts before the error; increment after the flag
`timescale 1ns/1ps
`default_nettype none
module cfc_fault_confine (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic BIT_TICK,
  input wire logic RX_PIN,
  input wire logic ERR_DET,
  input wire logic [2:0] ERR_KIND,
  input wire logic ACK_DELIM_END,
  input wire logic ACK_NO_DOM,
  input wire logic TX_ACTIVE,
  input wire logic SINGLE_SHOT,
  input wire logic INC_RX1,
  input wire logic INC_RX8,
  input wire logic DEC_TX,
  input wire logic DEC_RX,
  input wire logic INTERMISSION_END,
  input wire logic FRAME_RX_DONE,
  input wire logic INIT_REQ,
  input wire logic OP_MODE,
  output logic TRANSMIT_PIN,
  output logic [7:0] TRANSMIT_ERROR_COUNT,
  output logic [6:0] RECEIVE_ERROR_COUNT,
  output logic [1:0] TX_STATE_CODE,
  output logic [1:0] RX_STATE_CODE,
  output logic BUS_OFF_FLAG,
  output logic ERR_PASSIVE,
  output logic RETX_REQ,
  output logic TX_HOLD,
  output logic STORE_EN,
  output logic TIMESTAMP_TOGGLE_OUTPUT,
  output logic FRAME_VALID
);
  // ==========================================
  // pin synchroniser
  logic sync1, sync2, sync3, rx_level;
  always_ff @(posedge REF_CLK or negedge RST_N)
    if (!RST_N)
    begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      sync3 <= 1'b1;
      rx_level <= 1'b1;
    end
    else
    begin
      sync1 <= RX_PIN;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3)
        rx_level <= sync3;
    end

  // ==========================================
  // error frame sequencer
  cfc_pkg::cfc_ef_state_t ef_state;
  logic [3:0] bit_cnt;
  logic snap_passive, snap_tx, snap_tx_inc, snap_rx_inc;
  logic apply_now;
  logic [7:0] transmit_error_count, receive_error_count;
  always_ff @(posedge REF_CLK or negedge RST_N)
    if (!RST_N)
    begin
      ef_state <= cfc_pkg::EF_IDLE;
      bit_cnt <= 4'h0;
      snap_passive <= 1'b0;
      snap_tx <= 1'b0;
      snap_tx_inc <= 1'b0;
      snap_rx_inc <= 1'b0;
      apply_now <= 1'b0;
      RETX_REQ <= 1'b0;
      TRANSMIT_PIN <= 1'b1;
    end
    else
    begin
      apply_now <= 1'b0;
      RETX_REQ <= 1'b0;
      case (ef_state)
        cfc_pkg::EF_IDLE:
          if (ERR_DET && !BUS_OFF_FLAG)
          begin
            snap_passive <= ERR_PASSIVE;
            snap_tx <= TX_ACTIVE;
            snap_tx_inc <= TX_ACTIVE && !(ERR_PASSIVE && ERR_KIND == cfc_pkg::KIND_ACK
              && ACK_NO_DOM);
            snap_rx_inc <= !TX_ACTIVE;
            ef_state <= (ERR_KIND == cfc_pkg::KIND_CRC) ? cfc_pkg::EF_WAIT_CRC
              : cfc_pkg::EF_ARMED;
          end
        cfc_pkg::EF_WAIT_CRC:
          if (ACK_DELIM_END)
            ef_state <= cfc_pkg::EF_ARMED;
        cfc_pkg::EF_ARMED:
          if (BIT_TICK)
          begin
            ef_state <= cfc_pkg::EF_FLAG;
            bit_cnt <= 4'h1;
            TRANSMIT_PIN <= snap_passive;
          end
        cfc_pkg::EF_FLAG:
          if (BIT_TICK)
          begin
            if (bit_cnt == cfc_pkg::FLAG_BITS)
            begin
              ef_state <= cfc_pkg::EF_DELIM_WAIT;
              TRANSMIT_PIN <= 1'b1;
            end
            else
              bit_cnt <= bit_cnt + 4'h1;
          end
        cfc_pkg::EF_DELIM_WAIT:
          if (BIT_TICK && rx_level)
          begin
            ef_state <= cfc_pkg::EF_DELIM;
            bit_cnt <= 4'h1;
            apply_now <= 1'b1;
          end
        cfc_pkg::EF_DELIM:
          if (BIT_TICK)
          begin
            if (bit_cnt == cfc_pkg::DELIM_BITS)
            begin
              ef_state <= cfc_pkg::EF_IDLE;
              RETX_REQ <= snap_tx && !SINGLE_SHOT && !BUS_OFF_FLAG;
            end
            else
              bit_cnt <= bit_cnt + 4'h1;
          end
        default:
          ef_state <= cfc_pkg::EF_IDLE;
      endcase
      if (BUS_OFF_FLAG)
      begin
        TRANSMIT_PIN <= 1'b1;
        ef_state <= cfc_pkg::EF_IDLE;
      end
    end

  // ==========================================
  // bus-off recovery counting
  logic recover_armed, recover_done;
  logic [3:0] run_len;
  logic [7:0] run_cnt;
  always_ff @(posedge REF_CLK or negedge RST_N)
    if (!RST_N)
    begin
      recover_armed <= 1'b0;
      recover_done <= 1'b0;
      run_len <= 4'h0;
      run_cnt <= 8'h00;
    end
    else
    begin
      recover_done <= 1'b0;
      if (!BUS_OFF_FLAG || INIT_REQ)
      begin
        recover_armed <= BUS_OFF_FLAG && INIT_REQ;
        run_len <= 4'h0;
        run_cnt <= 8'h00;
      end
      else if (recover_armed && OP_MODE && BIT_TICK && !recover_done)
      begin
        if (!rx_level)
          run_len <= 4'h0;
        else if (run_len == cfc_pkg::IDLE_RUN_BITS - 4'h1)
        begin
          run_len <= 4'h0;
          run_cnt <= run_cnt + 8'h01;
          if (run_cnt == cfc_pkg::IDLE_RUNS - 8'h01)
            recover_done <= 1'b1;
        end
        else
          run_len <= run_len + 4'h1;
      end
    end

  // ==========================================
  // transmit error counter and bus-off
  always_ff @(posedge REF_CLK or negedge RST_N)
    if (!RST_N)
    begin
      transmit_error_count <= cfc_pkg::TEC_RESET;
      BUS_OFF_FLAG <= 1'b0;
    end
    else if (recover_done)
    begin
      transmit_error_count <= cfc_pkg::TEC_RESET;
      BUS_OFF_FLAG <= 1'b0;
    end
    else if (apply_now && snap_tx_inc)
    begin
      if (transmit_error_count >= cfc_pkg::TEC_OFF_LEVEL)
        BUS_OFF_FLAG <= 1'b1;
      else
        transmit_error_count <= transmit_error_count + cfc_pkg::TEC_STEP;
    end
    else if (DEC_TX && transmit_error_count != 8'h00 && !BUS_OFF_FLAG)
      transmit_error_count <= transmit_error_count - 8'h01;

  // ==========================================
  // receive error counter
  always_ff @(posedge REF_CLK or negedge RST_N)
    if (!RST_N)
      receive_error_count <= cfc_pkg::REC_RESET;
    else if (recover_done)
      receive_error_count <= cfc_pkg::REC_RESET;
    else if ((apply_now && snap_rx_inc) || INC_RX1 || INC_RX8)
    begin
      if (INC_RX8 && receive_error_count <= 8'hFF - cfc_pkg::REC_STEP)
        receive_error_count <= receive_error_count + cfc_pkg::REC_STEP;
      else if (INC_RX8)
        receive_error_count <= 8'hFF;
      else if (receive_error_count != 8'hFF)
        receive_error_count <= receive_error_count + 8'h01;
    end
    else if (DEC_RX)
    begin
      if (receive_error_count >= cfc_pkg::PASSIVE_LEVEL)
        receive_error_count <= cfc_pkg::REC_RELOAD;
      else if (receive_error_count != 8'h00)
        receive_error_count <= receive_error_count - 8'h01;
    end

  // ==========================================
  // status codes, visible counts
  always_ff @(posedge REF_CLK or negedge RST_N)
    if (!RST_N)
    begin
      TRANSMIT_ERROR_COUNT <= 8'h00;
      RECEIVE_ERROR_COUNT <= 7'h00;
      TX_STATE_CODE <= cfc_pkg::CODE_ACTIVE;
      RX_STATE_CODE <= cfc_pkg::CODE_ACTIVE;
      ERR_PASSIVE <= 1'b0;
    end
    else
    begin
      TRANSMIT_ERROR_COUNT <= transmit_error_count;
      RECEIVE_ERROR_COUNT <= (receive_error_count >= cfc_pkg::PASSIVE_LEVEL) ? 7'h7F : receive_error_count[6:0];
      if (BUS_OFF_FLAG || transmit_error_count >= cfc_pkg::PASSIVE_LEVEL)
        TX_STATE_CODE <= cfc_pkg::CODE_PASSIVE;
      else if (transmit_error_count >= cfc_pkg::WARN_LEVEL)
        TX_STATE_CODE <= cfc_pkg::CODE_WARN;
      else
        TX_STATE_CODE <= cfc_pkg::CODE_ACTIVE;
      if (receive_error_count >= cfc_pkg::PASSIVE_LEVEL)
        RX_STATE_CODE <= cfc_pkg::CODE_PASSIVE;
      else if (receive_error_count >= cfc_pkg::WARN_LEVEL)
        RX_STATE_CODE <= cfc_pkg::CODE_WARN;
      else
        RX_STATE_CODE <= cfc_pkg::CODE_ACTIVE;
      ERR_PASSIVE <= transmit_error_count >= cfc_pkg::PASSIVE_LEVEL || receive_error_count >= cfc_pkg::PASSIVE_LEVEL;
    end

  // ==========================================
  // suspend transmission
  logic tx_seen;
  logic [3:0] susp_cnt;
  always_ff @(posedge REF_CLK or negedge RST_N)
    if (!RST_N)
    begin
      tx_seen <= 1'b0;
      susp_cnt <= 4'h0;
      TX_HOLD <= 1'b0;
    end
    else
    begin
      if (INTERMISSION_END)
      begin
        tx_seen <= 1'b0;
        if (ERR_PASSIVE && (tx_seen || TX_ACTIVE))
          susp_cnt <= cfc_pkg::SUSPEND_BITS;
      end
      else
      begin
        if (TX_ACTIVE)
          tx_seen <= 1'b1;
        if (BIT_TICK && susp_cnt != 4'h0)
          susp_cnt <= susp_cnt - 4'h1;
      end
      TX_HOLD <= BUS_OFF_FLAG || (susp_cnt != 4'h0);
    end

  // ==========================================
  // receive frame reporting
  always_ff @(posedge REF_CLK or negedge RST_N)
    if (!RST_N)
    begin
      STORE_EN <= 1'b0;
      FRAME_VALID <= 1'b0;
      TIMESTAMP_TOGGLE_OUTPUT <= 1'b0;
    end
    else
    begin
      STORE_EN <= FRAME_RX_DONE && !BUS_OFF_FLAG;
      FRAME_VALID <= FRAME_RX_DONE;
      if (FRAME_RX_DONE)
        TIMESTAMP_TOGGLE_OUTPUT <= !TIMESTAMP_TOGGLE_OUTPUT;
    end

  // ==========================================
  // assertions
  property p_flag_start;
    @(posedge REF_CLK) disable iff (!RST_N)
    (ef_state == cfc_pkg::EF_ARMED && BIT_TICK && !BUS_OFF_FLAG) |=>
      ef_state == cfc_pkg::EF_FLAG && TRANSMIT_PIN == snap_passive;
  endproperty
  a_flag_start: assert property (p_flag_start) else $error("flag not started");
  property p_crc_wait;
    @(posedge REF_CLK) disable iff (!RST_N)
    (ef_state == cfc_pkg::EF_WAIT_CRC && !ACK_DELIM_END && !BUS_OFF_FLAG) |=>
      ef_state == cfc_pkg::EF_WAIT_CRC;
  endproperty
  a_crc_wait: assert property (p_crc_wait) else $error("crc flag too early");
  property p_no_retx_single;
    @(posedge REF_CLK) disable iff (!RST_N)
    SINGLE_SHOT && $past(SINGLE_SHOT) |-> !RETX_REQ;
  endproperty
  a_no_retx_single: assert property (p_no_retx_single) else $error("resend in one shot");
  property p_warn_code;
    @(posedge REF_CLK) disable iff (!RST_N)
    $stable(transmit_error_count) && !BUS_OFF_FLAG && transmit_error_count >= cfc_pkg::WARN_LEVEL
      && transmit_error_count < cfc_pkg::PASSIVE_LEVEL |=> TX_STATE_CODE == cfc_pkg::CODE_WARN;
  endproperty
  a_warn_code: assert property (p_warn_code) else $error("warning code wrong");
  property p_passive_code;
    @(posedge REF_CLK) disable iff (!RST_N)
    receive_error_count >= cfc_pkg::PASSIVE_LEVEL |=> RX_STATE_CODE == cfc_pkg::CODE_PASSIVE && ERR_PASSIVE;
  endproperty
  a_passive_code: assert property (p_passive_code) else $error("passive code wrong");
  property p_off_hold;
    @(posedge REF_CLK) disable iff (!RST_N)
    apply_now && snap_tx_inc && transmit_error_count >= cfc_pkg::TEC_OFF_LEVEL && !recover_done |=>
      BUS_OFF_FLAG && $stable(transmit_error_count);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("bus-off entry wrong");
  property p_pin_recessive;
    @(posedge REF_CLK) disable iff (!RST_N)
    BUS_OFF_FLAG ##1 BUS_OFF_FLAG |-> TRANSMIT_PIN;
  endproperty
  a_pin_recessive: assert property (p_pin_recessive) else $error("pin driven in bus-off");
  property p_no_store_off;
    @(posedge REF_CLK) disable iff (!RST_N)
    FRAME_RX_DONE && BUS_OFF_FLAG |=> !STORE_EN && FRAME_VALID;
  endproperty
  a_no_store_off: assert property (p_no_store_off) else $error("stored in bus-off");
  // bit ticks seen while the flag stands, kept apart from bit_cnt
  logic [3:0] flag_ticks;
  always_ff @(posedge REF_CLK or negedge RST_N)
    if (!RST_N)
      flag_ticks <= 4'h0;
    else if (ef_state == cfc_pkg::EF_FLAG)
      flag_ticks <= flag_ticks + {3'h0, BIT_TICK};
    else
      flag_ticks <= 4'h0;
  property p_flag_len;
    @(posedge REF_CLK) disable iff (!RST_N)
    $rose(ef_state == cfc_pkg::EF_DELIM_WAIT) |-> flag_ticks == cfc_pkg::FLAG_BITS;
  endproperty
  a_flag_len: assert property (p_flag_len) else $error("flag length wrong");
  c_active_flag: cover property (@(posedge REF_CLK) ef_state == cfc_pkg::EF_FLAG && !TRANSMIT_PIN);
  c_bus_off: cover property (@(posedge REF_CLK) $rose(BUS_OFF_FLAG));
  c_recover: cover property (@(posedge REF_CLK) recover_done);
  c_retx: cover property (@(posedge REF_CLK) RETX_REQ);
endmodule : cfc_fault_confine
`default_nettype wire

// File: dv/cfc_bus_model.sv
// Purpose: the other nodes on the shared bus, wired with this node
// Assumes: the bus idles recessive through its pull-up
// Notes: other_dom lets the bench hold the bus dominant
`timescale 1ns/1ps
`default_nettype none
module cfc_bus_model (
  input wire logic tx_pin,
  input wire logic other_dom,
  output wire logic rx_level
);
  // ==========================================
  // bus level: dominant wins, else pulled recessive
  assign rx_level = tx_pin & ~other_dom;
endmodule : cfc_bus_model
`default_nettype wire

// File: dv/cfc_fault_confine_tb_top.sv
// Purpose: self-checking bench for the fault confinement block
// Assumes: four clocks per bit period, bit ticks made here
// Notes: bus-off recovery runs the full count of idle runs
`timescale 1ns/1ps
`default_nettype none
module cfc_fault_confine_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tick = 1'b0;
  logic [1:0] bc = 2'h0;
  logic det, dend, nodom, txa, one, i1, i8, dtx, drx, iend, fdone, ireq, opm, rx;
  logic [2:0] kind;
  logic pin, bus_off_flag, epas, retx, hold, store, tstog, fval;
  logic [7:0] transmit_error_count;
  logic [6:0] receive_error_count;
  logic [1:0] tcode, rcode;
  logic [7:0] exp_tec = 8'h00;
  logic exp_off = 1'b0;
  int err_count = 0;
  int n_tests = 0;
  localparam logic [4:0] P_IEND = 5'h01;
  localparam logic [4:0] P_DRX = 5'h02;
  localparam logic [4:0] P_DTX = 5'h04;
  localparam logic [4:0] P_I8 = 5'h08;
  localparam logic [4:0] P_I1 = 5'h10;
  // ==========================================
  // clock, bit ticks, design and bus
  initial
  begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    bc <= bc + 2'h1;
    tick <= (bc == 2'h2);
  end
  cfc_fault_confine i_cfc_fault_confine (
    .REF_CLK(clk), .RST_N(rst_n), .BIT_TICK(tick), .RX_PIN(rx), .ERR_DET(det),
    .ERR_KIND(kind), .ACK_DELIM_END(dend), .ACK_NO_DOM(nodom), .TX_ACTIVE(txa),
    .SINGLE_SHOT(one), .INC_RX1(i1), .INC_RX8(i8), .DEC_TX(dtx), .DEC_RX(drx),
    .INTERMISSION_END(iend), .FRAME_RX_DONE(fdone), .INIT_REQ(ireq), .OP_MODE(opm),
    .TRANSMIT_PIN(pin), .TRANSMIT_ERROR_COUNT(transmit_error_count), .RECEIVE_ERROR_COUNT(receive_error_count),
    .TX_STATE_CODE(tcode), .RX_STATE_CODE(rcode), .BUS_OFF_FLAG(bus_off_flag),
    .ERR_PASSIVE(epas), .RETX_REQ(retx), .TX_HOLD(hold), .STORE_EN(store),
    .TIMESTAMP_TOGGLE_OUTPUT(tstog), .FRAME_VALID(fval)
  );
  cfc_bus_model i_cfc_bus_model (.tx_pin(pin), .other_dom(1'b0), .rx_level(rx));
  // ==========================================
  // checking and closing
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  function automatic logic [7:0] code_of(input logic [7:0] v);
    if (v >= cfc_pkg::PASSIVE_LEVEL)
      return {6'h00, cfc_pkg::CODE_PASSIVE};
    if (v >= cfc_pkg::WARN_LEVEL)
      return {6'h00, cfc_pkg::CODE_WARN};
    return {6'h00, cfc_pkg::CODE_ACTIVE};
  endfunction : code_of
  // ==========================================
  // access tasks
  task automatic err_frame(input logic [2:0] k, input logic txr, input int n_low,
                           input int n_retx);
    int low;
    int first;
    int rt;
    low = 0;
    first = 0;
    rt = 0;
    @(posedge clk);
    txa <= txr;
    kind <= k;
    det <= 1'b1;
    @(posedge clk);
    det <= 1'b0;
    for (int i = 1; i < 110; i++)
    begin
      dend <= (k == cfc_pkg::KIND_CRC && i == 12);
      @(negedge clk);
      if (pin !== 1'b1)
      begin
        low++;
        if (first == 0)
          first = i;
      end
      if (retx === 1'b1)
        rt++;
      @(posedge clk);
    end
    check(8'(low), 8'(n_low));
    check(8'(rt), 8'(n_retx));
    if (n_low > 0)
      check(8'(k == cfc_pkg::KIND_CRC ? (first > 13 && first < 18) : (first > 1 && first < 6)),
            8'h01);
  endtask : err_frame
  task automatic tx_err(input logic [2:0] k, input int n_retx);
    logic act;
    act = exp_tec < cfc_pkg::PASSIVE_LEVEL;
    err_frame(k, 1'b1, act ? 24 : 0, n_retx);
    if (exp_tec >= cfc_pkg::TEC_OFF_LEVEL)
      exp_off = 1'b1;
    else if (!(nodom && !act && k == cfc_pkg::KIND_ACK))
      exp_tec = exp_tec + cfc_pkg::TEC_STEP;
    check(transmit_error_count, exp_tec);
    check({6'h00, tcode}, code_of(exp_tec));
    check({7'h00, bus_off_flag}, {7'h00, exp_off});
  endtask : tx_err
  task automatic pulse(input logic [4:0] m);
    @(posedge clk);
    {i1, i8, dtx, drx, iend} <= m;
    @(posedge clk);
    {i1, i8, dtx, drx, iend} <= 5'h00;
    @(negedge clk);
    @(negedge clk);
  endtask : pulse
  task automatic frm(input logic exp_st);
    int nv;
    int ns;
    logic t0;
    nv = 0;
    ns = 0;
    t0 = tstog;
    @(posedge clk);
    fdone <= 1'b1;
    @(posedge clk);
    fdone <= 1'b0;
    repeat (3)
    begin
      @(negedge clk);
      if (fval === 1'b1)
        nv++;
      if (store === 1'b1)
        ns++;
    end
    check(8'(nv), 8'h01);
    check(8'(ns), {7'h00, exp_st});
    check({7'h00, tstog ^ t0}, 8'h01);
  endtask : frm
  // ==========================================
  // tests
  initial
  begin
    int n;
    {det, dend, nodom, txa, one, i1, i8, dtx, drx, iend, fdone, ireq, opm} = '0;
    kind = 3'h0;
    @(negedge clk);
    check({1'b0, pin, bus_off_flag, epas, tcode, rcode}, 8'h40);
    check({1'b0, receive_error_count}, 8'h00);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    check(transmit_error_count, 8'h00);
    frm(1'b1);
    err_frame(cfc_pkg::KIND_CRC, 1'b0, 24, 0);
    repeat (12) pulse(P_I8);
    pulse(P_DRX);
    check({1'b0, receive_error_count}, 8'h60);
    check({6'h00, rcode}, code_of(8'h60));
    pulse(P_I1);
    check({1'b0, receive_error_count}, 8'h61);
    repeat (4) pulse(P_I8);
    check({1'b0, receive_error_count}, 8'h7F);
    check({6'h00, rcode}, code_of(8'h81));
    check({7'h00, epas}, 8'h01);
    pulse(P_DRX);
    check({1'b0, receive_error_count}, 8'h7F);
    check({6'h00, rcode}, code_of(8'h7F));
    check({7'h00, epas}, 8'h00);
    tx_err(cfc_pkg::KIND_BIT, 1);
    pulse(P_DTX);
    exp_tec = 8'h07;
    check(transmit_error_count, exp_tec);
    for (int i = 0; i < 16; i++)
      tx_err(3'(i % 4), 1);
    check({7'h00, epas}, 8'h01);
    nodom <= 1'b1;
    tx_err(cfc_pkg::KIND_ACK, 1);
    nodom <= 1'b0;
    one <= 1'b1;
    tx_err(cfc_pkg::KIND_BIT, 0);
    one <= 1'b0;
    pulse(P_IEND);
    n = 0;
    repeat (48)
    begin
      if (hold === 1'b1)
        n++;
      @(negedge clk);
    end
    check(8'(n >= 28 && n <= 33), 8'h01);
    while (exp_tec < cfc_pkg::TEC_OFF_LEVEL)
      tx_err(cfc_pkg::KIND_FORM, 1);
    tx_err(cfc_pkg::KIND_STUFF, 0);
    err_frame(cfc_pkg::KIND_BIT, 1'b1, 0, 0);
    frm(1'b0);
    ireq <= 1'b1;
    repeat (4) @(posedge clk);
    ireq <= 1'b0;
    opm <= 1'b1;
    repeat (5400) @(posedge clk);
    check({7'h00, bus_off_flag}, 8'h01);
    for (int i = 0; i < 600 && bus_off_flag !== 1'b0; i++)
      @(posedge clk);
    @(negedge clk);
    check({1'b0, receive_error_count}, 8'h00);
    check(transmit_error_count, 8'h00);
    check({3'h0, bus_off_flag, tcode, rcode}, 8'h00);
    close_out();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out();
  end
endmodule : cfc_fault_confine_tb_top
`default_nettype wire
